// file: rtl/rftmr_regs.vh
// register map, field positions and reset values of the rf frontend timer bank
`ifndef RFTMR_REGS_VH
`define RFTMR_REGS_VH

// register indices; the byte address on the bus is four times the index
`define RFTMR_IDX_RUN_CONTROL 6'h0e
`define RFTMR_IDX_T0_CONTROL 6'h0f
`define RFTMR_IDX_T0_RELOAD_HIGH 6'h10
`define RFTMR_IDX_T0_RELOAD_LOW 6'h11
`define RFTMR_IDX_T0_COUNT_HIGH 6'h12
`define RFTMR_IDX_T0_COUNT_LOW 6'h13
`define RFTMR_IDX_T1_CONTROL 6'h14

// run control: active flags in the upper nibble, write masks in the lower
`define RFTMR_RUN_FLAG_LSB 4
`define RFTMR_RUN_FLAG_MSB 7
`define RFTMR_RUN_MASK_LSB 0
`define RFTMR_RUN_MASK_MSB 3

// timer control fields
`define RFTMR_CTL_HALT_RX 7
`define RFTMR_CTL_START_MSB 5
`define RFTMR_CTL_START_LSB 4
`define RFTMR_CTL_AUTO_RELOAD 3
`define RFTMR_CTL_CLK_MSB 1
`define RFTMR_CTL_CLK_LSB 0

// start mode encodings
`define RFTMR_START_NONE 2'h0
`define RFTMR_START_TX_END 2'h1
`define RFTMR_START_TRIM 2'h2
`define RFTMR_START_TRIM_UF 2'h3

// clock select encodings for timer0
`define RFTMR_CLK_CARRIER 2'h0
`define RFTMR_CLK_DIVIDED 2'h1
`define RFTMR_CLK_T2_UF 2'h2
`define RFTMR_CLK_T1_UF 2'h3

// reset values
`define RFTMR_RST_CONTROL 8'h00
`define RFTMR_RST_RELOAD 8'h00
`define RFTMR_RST_COUNT 16'h0000
`define RFTMR_RST_FLAGS 4'h0

`endif

// file: rtl/rftmr_down_counter.v
// loadable down counter with zero detect
`timescale 1ns/1ps
module rftmr_down_counter #(
	parameter WIDTH = 16
) (
	input wire clk_sys,
	input wire rst_n,
	input wire load,
	input wire [WIDTH-1:0] load_value,
	input wire dec,
	output wire [WIDTH-1:0] count,
	output wire at_zero
);

	reg [WIDTH-1:0] count_r;
	reg [WIDTH-1:0] count_nxt;

	// load wins over decrement so a restart never loses the fresh value
	always @*
	begin
		count_nxt = count_r;
		if (load)
			count_nxt = load_value;
		else if (dec)
			count_nxt = count_r - {{(WIDTH-1){1'b0}}, 1'b1};
	end

	// synchronous reset to zero
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			count_r <= {WIDTH{1'b0}};
		else
			count_r <= count_nxt;
	end

	assign count = count_r;
	assign at_zero = (count_r == {WIDTH{1'b0}});

endmodule // rftmr_down_counter

// file: rtl/rftmr_timer_bank.v
// timer bank: run control for four timers, timer0 in full, timer1 halt-on-receive, avalon slave
`timescale 1ns/1ps
`include "rftmr_regs.vh"
module rftmr_timer_bank #(
	parameter CNT_WIDTH = 16
) (
	input wire clk_sys,
	input wire rst_n,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire carrier_clk_pin,
	input wire divided_clk_pin,
	input wire low_frequency_oscillator_pin,
	input wire tx_end_pulse,
	input wire rx_first4_pulse,
	input wire timer1_underflow,
	input wire timer2_underflow,
	input wire timer1_done,
	input wire timer2_done,
	input wire timer3_done,
	input wire irq_flag_clear,
	output wire [3:1] timer_active_out,
	output wire timer0_underflow,
	output wire timer_underflow_irq_flag
);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge detect

	reg [2:0] carrier_sync_r;
	reg [2:0] divided_sync_r;
	reg [2:0] osc_sync_r;

	// two stages guard against metastability, the third only remembers the last level,
	// so a tick lags its pin edge by two clock edges
	// reset fills every stage with zero, the idle level of the pins, so no false edge follows
	// stage 0 feeds only stage 1; the edge detector looks at stages 1 and 2
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			carrier_sync_r <= 3'h0;
			divided_sync_r <= 3'h0;
			osc_sync_r <= 3'h0;
		end
		else
		begin
			carrier_sync_r <= {carrier_sync_r[1:0], carrier_clk_pin};
			divided_sync_r <= {divided_sync_r[1:0], divided_clk_pin};
			osc_sync_r <= {osc_sync_r[1:0], low_frequency_oscillator_pin};
		end
	end

	wire carrier_tick;
	wire divided_tick;
	wire osc_rise;

	// one-cycle ticks on each rising edge of the sampled pins
	assign carrier_tick = carrier_sync_r[1] & ~carrier_sync_r[2];
	assign divided_tick = divided_sync_r[1] & ~divided_sync_r[2];
	// the trim edge has an identical synchroniser so its timing matches the clock ticks
	assign osc_rise = osc_sync_r[1] & ~osc_sync_r[2];

	////////////////////////////////////////////////////////////////////////////
	// avalon slave handshake

	reg ack_r;
	reg [31:0] readdata_r;
	wire bus_req;
	wire wr_fire;
	wire [5:0] reg_idx;
	wire lane0;

	// one wait state: the request is answered at the second edge it is held
	assign bus_req = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~ack_r;
	// address bits 1:0 are ignored, every register sits on its own word
	assign reg_idx = avs_address[7:2];
	assign lane0 = avs_byteenable[0];
	// writes act only at the edge where waitrequest is low
	assign wr_fire = avs_write & ack_r & lane0;

	wire wr_run = wr_fire & (reg_idx == `RFTMR_IDX_RUN_CONTROL);
	wire wr_t0ctl = wr_fire & (reg_idx == `RFTMR_IDX_T0_CONTROL);
	wire wr_rel_hi = wr_fire & (reg_idx == `RFTMR_IDX_T0_RELOAD_HIGH);
	wire wr_rel_lo = wr_fire & (reg_idx == `RFTMR_IDX_T0_RELOAD_LOW);
	wire wr_t1ctl = wr_fire & (reg_idx == `RFTMR_IDX_T1_CONTROL);
	wire [7:0] wdata = avs_writedata[7:0];

	// ack toggles so that every request sees exactly one wait state;
	// a master that holds its request past the answer starts a second access
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			ack_r <= 1'b0;
		else
			ack_r <= bus_req & ~ack_r;
	end

	////////////////////////////////////////////////////////////////////////////
	// configuration registers

	reg [7:0] t0_control_r;
	reg [7:0] reload_high_r;
	reg [7:0] reload_low_r;
	reg t1_halt_rx_r;

	// only byte lane 0 carries data; timer1 keeps only its halt bit here
	// reserved bits 6 and 2 are not stored and read back as zero
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			t0_control_r <= `RFTMR_RST_CONTROL;
			reload_high_r <= `RFTMR_RST_RELOAD;
			reload_low_r <= `RFTMR_RST_RELOAD;
			t1_halt_rx_r <= 1'b0;
		end
		else
		begin
			if (wr_t0ctl)
				t0_control_r <= wdata & 8'hbb;
			if (wr_rel_hi)
				reload_high_r <= wdata;
			if (wr_rel_lo)
				reload_low_r <= wdata;
			if (wr_t1ctl)
				t1_halt_rx_r <= wdata[`RFTMR_CTL_HALT_RX];
		end
	end

	// field views of the timer0 control byte
	wire t0_halt_rx = t0_control_r[`RFTMR_CTL_HALT_RX];
	wire [1:0] t0_start_mode = t0_control_r[`RFTMR_CTL_START_MSB:`RFTMR_CTL_START_LSB];
	wire t0_auto_reload = t0_control_r[`RFTMR_CTL_AUTO_RELOAD];
	wire [1:0] t0_clock_select = t0_control_r[`RFTMR_CTL_CLK_MSB:`RFTMR_CTL_CLK_LSB];
	wire [CNT_WIDTH-1:0] reload_value = {reload_high_r, reload_low_r};

	////////////////////////////////////////////////////////////////////////////
	// timer0 tick selection

	reg t0_tick;

	// underflow inputs let timers be chained into longer counts
	// the pins must stay high and low for a clk_sys period each, or edges are lost
	always @*
	begin
		case (t0_clock_select)
			`RFTMR_CLK_CARRIER: t0_tick = carrier_tick;
			`RFTMR_CLK_DIVIDED: t0_tick = divided_tick;
			`RFTMR_CLK_T2_UF: t0_tick = timer2_underflow;
			`RFTMR_CLK_T1_UF: t0_tick = timer1_underflow;
			default: t0_tick = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// timer0 start, stop and underflow decisions

	reg [3:0] active_r;
	reg [3:0] active_nxt;
	wire [CNT_WIDTH-1:0] t0_count;
	wire t0_at_zero;
	wire t0_running = active_r[0];
	wire t0_trim = t0_start_mode[1];

	// software mask for timer0 with a set value starts it from idle
	wire sw_t0_sel = wr_run & wdata[`RFTMR_RUN_MASK_LSB];
	wire sw_t0_val = wdata[`RFTMR_RUN_FLAG_LSB];

	// hardware start sources depend on start mode
	wire hw_start_tx = (t0_start_mode == `RFTMR_START_TX_END) & tx_end_pulse;
	wire hw_start_trim = t0_trim & osc_rise & ~t0_running;
	wire hw_stop_trim = t0_trim & osc_rise & t0_running;

	// receive halt only outside the trimming modes
	wire hw_stop_rx = t0_halt_rx & ~t0_trim & rx_first4_pulse;

	// hardware start and stop causes of timer0 other than the end of the count, which the flag block handles
	wire t0_hw_start = hw_start_tx | hw_start_trim;
	wire t0_hw_stop = hw_stop_trim | hw_stop_rx;

	// an expired count in mode 2 holds at zero with no underflow
	wire t0_expire = t0_running & t0_tick & t0_at_zero;
	wire t0_uf = t0_expire & (t0_start_mode != `RFTMR_START_TRIM);

	// a start from idle loads the reload value; a software set of a running
	// timer reloads as well, so a restart always counts a full period
	wire sw_start = sw_t0_sel & sw_t0_val;
	wire t0_start = sw_start | (t0_hw_start & ~sw_t0_sel);
	// a software write in the same cycle decides instead of the reload
	wire t0_reload = t0_uf & t0_auto_reload & ~sw_t0_sel;
	wire t0_load = t0_start | t0_reload;
	// limitation: a tick that meets a load is lost, the fresh value wins
	wire t0_dec = t0_running & t0_tick & ~t0_at_zero & ~t0_load;

	// one shared counter module keeps the load-over-decrement order in one place
	rftmr_down_counter #(
		.WIDTH(CNT_WIDTH)
	) u_t0_counter (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.load(t0_load),
		.load_value(reload_value),
		.dec(t0_dec),
		.count(t0_count),
		.at_zero(t0_at_zero)
	);

	////////////////////////////////////////////////////////////////////////////
	// running flags of all four timers

	integer i;

	// hardware events act first, a masked software write has the last word,
	// so a done pulse and a masked set in one cycle leave the timer running
	always @*
	begin
		active_nxt = active_r;
		// timer0 hardware events
		if (t0_hw_start)
			active_nxt[0] = 1'b1;
		if (t0_hw_stop)
			active_nxt[0] = 1'b0;
		if (t0_uf & ~t0_auto_reload)
			active_nxt[0] = 1'b0;
		if (t0_expire & (t0_start_mode == `RFTMR_START_TRIM))
			active_nxt[0] = 1'b0;
		// timers 1 to 3 count outside this block; only their flags live here
		// other timers report their own end; timer1 also halts on receive
		if (timer1_done | (t1_halt_rx_r & rx_first4_pulse))
			active_nxt[1] = 1'b0;
		if (timer2_done)
			active_nxt[2] = 1'b0;
		if (timer3_done)
			active_nxt[3] = 1'b0;
		// masked write: only bits whose mask is one take the written value
		if (wr_run)
		begin
			for (i = 0; i < 4; i = i + 1)
			begin
				if (wdata[`RFTMR_RUN_MASK_LSB + i])
					active_nxt[i] = wdata[`RFTMR_RUN_FLAG_LSB + i];
			end
		end
	end

	// running flags of all four timers, cleared by reset
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			active_r <= `RFTMR_RST_FLAGS;
		else
			active_r <= active_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// underflow flag and cascade pulse

	reg irq_flag_r;
	reg t0_uf_r;

	// a new underflow beats a clear in the same cycle
	// the clear input stands in for a write-one-to-clear register bit
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			irq_flag_r <= 1'b0;
			t0_uf_r <= 1'b0;
		end
		else
		begin
			t0_uf_r <= t0_uf;
			if (t0_uf)
				irq_flag_r <= 1'b1;
			else if (irq_flag_clear)
				irq_flag_r <= 1'b0;
		end
	end

	// flag and cascade pulse rise at the same edge, straight from flip-flops
	assign timer_underflow_irq_flag = irq_flag_r;
	assign timer0_underflow = t0_uf_r;
	assign timer_active_out = active_r[3:1];

	////////////////////////////////////////////////////////////////////////////
	// read mux

	reg [7:0] rd_byte;

	// mask bits are write-only and read as zero; unmapped addresses read zero
	// the count bytes are not latched as a pair, so a read during reception
	// or while ticking fast can tear between high and low byte
	// reads have no side effects, so a read may be repeated freely
	always @*
	begin
		case (reg_idx)
			`RFTMR_IDX_RUN_CONTROL: rd_byte = {active_r, 4'h0};
			`RFTMR_IDX_T0_CONTROL: rd_byte = t0_control_r;
			`RFTMR_IDX_T0_RELOAD_HIGH: rd_byte = reload_high_r;
			`RFTMR_IDX_T0_RELOAD_LOW: rd_byte = reload_low_r;
			`RFTMR_IDX_T0_COUNT_HIGH: rd_byte = t0_count[15:8];
			`RFTMR_IDX_T0_COUNT_LOW: rd_byte = t0_count[7:0];
			`RFTMR_IDX_T1_CONTROL: rd_byte = {t1_halt_rx_r, 7'h00};
			default: rd_byte = 8'h00;
		endcase
	end

	// data captured on the first edge stands through the answering cycle
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			readdata_r <= 32'h00000000;
		else if (avs_read & ~ack_r)
			readdata_r <= {24'h000000, rd_byte};
	end

	// upper lanes always read zero
	assign avs_readdata = readdata_r;

endmodule // rftmr_timer_bank

// file: verif/rftmr_timer_bank_assertions.sv
// port-level checker for the timer bank
`timescale 1ns/1ps
module rftmr_timer_bank_chk (
	input wire clk_sys,
	input wire rst_n,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire timer3_done,
	input wire irq_flag_clear,
	input wire [3:1] timer_active_out,
	input wire timer0_underflow,
	input wire timer_underflow_irq_flag
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	// bus: one wait state, never stuck high
	property p_wait_first;
		$rose(avs_read | avs_write) |-> avs_waitrequest;
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("no wait state");
	property p_wait_one;
		avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait too long");
	property p_idle;
		!(avs_read | avs_write) |-> !avs_waitrequest;
	endproperty
	a_idle: assert property (p_idle) else $error("wait while idle");
	property p_rd_hi;
		avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
	endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
	////////////////////////////////////////
	// underflow flag and cascade pulse rise at the same edge; the flag is sticky
	property p_uf_flag;
		timer0_underflow |-> timer_underflow_irq_flag;
	endproperty
	a_uf_flag: assert property (p_uf_flag) else $error("pulse without flag");
	property p_flag_rise;
		$rose(timer_underflow_irq_flag) |-> timer0_underflow;
	endproperty
	a_flag_rise: assert property (p_flag_rise) else $error("flag without pulse");
	property p_clr;
		irq_flag_clear |=> !timer_underflow_irq_flag || timer0_underflow;
	endproperty
	a_clr: assert property (p_clr) else $error("flag not cleared");
	property p_hold;
		timer_underflow_irq_flag && !irq_flag_clear |=> timer_underflow_irq_flag;
	endproperty
	a_hold: assert property (p_hold) else $error("flag lost");
	property p_pulse;
		timer0_underflow |=> !timer0_underflow;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse too long");
	property p_t3;
		timer3_done |=> !timer_active_out[3];
	endproperty
	a_t3: assert property (p_t3) else $error("timer3 still active");
endmodule // rftmr_timer_bank_chk
bind rftmr_timer_bank rftmr_timer_bank_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .timer3_done(timer3_done), .irq_flag_clear(irq_flag_clear),
	.timer_active_out(timer_active_out), .timer0_underflow(timer0_underflow),
	.timer_underflow_irq_flag(timer_underflow_irq_flag));

// file: verif/rf_frontend_timer_bank_bench.sv
// self-checking bench for the timer bank
`timescale 1ns/1ps
`include "rftmr_regs.vh"
module rf_frontend_timer_bank_bench;
	localparam [7:0] run_a = {`RFTMR_IDX_RUN_CONTROL, 2'h0};
	localparam [7:0] ctl_a = {`RFTMR_IDX_T0_CONTROL, 2'h0};
	localparam [7:0] rhi_a = {`RFTMR_IDX_T0_RELOAD_HIGH, 2'h0};
	localparam [7:0] rlo_a = {`RFTMR_IDX_T0_RELOAD_LOW, 2'h0};
	localparam [7:0] chi_a = {`RFTMR_IDX_T0_COUNT_HIGH, 2'h0};
	localparam [7:0] clo_a = {`RFTMR_IDX_T0_COUNT_LOW, 2'h0};
	localparam [7:0] t1_a = {`RFTMR_IDX_T1_CONTROL, 2'h0};
	logic clk_sys, rst_n, avs_read, avs_write;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata;
	logic [8:0] ev; // pins 0..2, then tx, rx, t1 uf, t2 uf, t3 done, clear
	wire [31:0] rdata;
	wire wreq, uf, irq;
	wire [3:1] act;
	logic [7:0] q[$];
	logic [4:0] uq[$]; // {pulse, timers 3..1, flag} expected at each underflow pulse
	int fails, n_compared;
	int src[4] = '{0, 1, 6, 5};
	int wd[4] = '{3, 3, 1, 1};
	rftmr_timer_bank DUT (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(rdata),
		.avs_waitrequest(wreq), .carrier_clk_pin(ev[0]), .divided_clk_pin(ev[1]),
		.low_frequency_oscillator_pin(ev[2]),
		.tx_end_pulse(ev[3]), .rx_first4_pulse(ev[4]), .timer1_underflow(ev[5]), .timer2_underflow(ev[6]),
		.timer1_done(1'b0), .timer2_done(1'b0), .timer3_done(ev[7]), .irq_flag_clear(ev[8]),
		.timer_active_out(act), .timer0_underflow(uf), .timer_underflow_irq_flag(irq));
	////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== {24'h0, exp})
		begin
			fails++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, {24'h0, exp});
		end
	endtask
	// pin levels: underflow pulse, active flags of timers 3..1, underflow flag
	task chk_pin(input logic [4:0] got, exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: pins %h, expected %h", $time, got, exp);
		end
	endtask
	// request held until waitrequest is sampled low
	task bus(input logic w, input logic [7:0] a, d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		do
			@(posedge clk_sys);
		while (wreq !== 1'b0);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task wr(input logic [7:0] a, d);
		bus(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, e);
		q.push_back(e);
		bus(1'b0, a, 8'h0);
	endtask
	// pins need a few cycles to pass the synchroniser
	task pl(input int b, w);
		ev[b] <= 1'b1;
		repeat (w) @(posedge clk_sys);
		ev[b] <= 1'b0;
		repeat (5) @(posedge clk_sys);
	endtask
	task fin(input string s);
		$display("test %s done", s);
	endtask
	task give_verdict;
		if (uq.size() != 0)
		begin
			fails++;
			$display("unexpected at %0t: %h underflow notes left, expected %h", $time, uq.size(), 0);
		end
		$display("compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////
	// watcher: every completed read takes the oldest note
	always @(posedge clk_sys)
		if (avs_read && wreq === 1'b0)
			chk(rdata, q.pop_front());
	// watcher: every underflow pulse takes the oldest underflow note
	always @(posedge clk_sys)
		if (rst_n === 1'b1 && uf !== 1'b0)
			chk_pin({uf, act, irq}, (uq.size() > 0) ? uq.pop_front() : 5'h00);
	initial
	begin
		clk_sys = 0;
		forever #5 clk_sys = ~clk_sys;
	end
	// watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		#200000;
		fails++;
		give_verdict;
	end
	initial
	begin
		logic [15:0] v;
		rst_n = 0;
		avs_read = 0;
		avs_write = 0;
		avs_address = 0;
		avs_writedata = 0;
		ev = 0;
		void'($urandom(32'hfa56));
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(run_a, 8'h00);
		rd(8'hfc, 8'h00);
		wr(ctl_a, 8'hff);
		rd(ctl_a, 8'hbb);
		wr(ctl_a, 8'h00);
		fin("reset");
		wr(run_a, 8'hf0);
		rd(run_a, 8'h00);
		v = 16'($urandom);
		v[0] = 1'b1; // low byte never zero, so no borrow below
		wr(rhi_a, v[15:8]);
		wr(rlo_a, v[7:0]);
		wr(run_a, 8'h11);
		rd(run_a, 8'h10);
		rd(chi_a, v[15:8]);
		pl(0, 3);
		rd(clo_a, v[7:0] - 8'h01);
		wr(rlo_a, ~v[7:0]);
		pl(1, 3);
		rd(clo_a, v[7:0] - 8'h01);
		wr(run_a, 8'h01);
		rd(run_a, 8'h00);
		fin("mask");
		wr(rhi_a, 8'h00);
		wr(rlo_a, 8'h02);
		wr(run_a, 8'h11);
		uq.push_back(5'h11);
		repeat (3) pl(0, 3);
		rd(run_a, 8'h00);
		pl(8, 1);
		chk_pin({uf, act, irq}, 5'h00);
		wr(ctl_a, 8'h08);
		wr(run_a, 8'h11);
		uq.push_back(5'h11);
		repeat (3) pl(0, 3);
		rd(clo_a, 8'h02);
		chk_pin({uf, act, irq}, 5'h01);
		rd(run_a, 8'h10);
		fin("underflow");
		for (int s = 0; s < 4; s++)
		begin
			wr(ctl_a, s[7:0]);
			wr(run_a, 8'h11);
			pl(src[(s + 1) % 4], wd[(s + 1) % 4]);
			pl(src[s], wd[s]);
			rd(clo_a, 8'h01);
		end
		wr(run_a, 8'h01);
		fin("clock select");
		for (int m = 0; m < 2; m++)
		begin
			wr(ctl_a, m[0] ? 8'h10 : 8'h00);
			pl(3, 1);
			rd(run_a, m[0] ? 8'h10 : 8'h00);
		end
		wr(ctl_a, 8'h90);
		pl(3, 1);
		pl(4, 1);
		rd(run_a, 8'h00);
		wr(ctl_a, 8'h10);
		pl(3, 1);
		pl(4, 1);
		rd(run_a, 8'h10);
		wr(run_a, 8'h01);
		pl(8, 1);
		for (int m = 2; m < 4; m++)
		begin
			wr(ctl_a, m[0] ? 8'hb0 : 8'ha0);
			pl(2, 3);
			pl(4, 1);
			rd(run_a, 8'h10);
			pl(2, 3);
			rd(run_a, 8'h00);
			pl(2, 3);
			if (m == 3)
				uq.push_back(5'h11);
			repeat (3) pl(0, 3);
			rd(run_a, 8'h00);
			chk_pin({uf, act, irq}, {4'h0, m[0]});
		end
		fin("start modes");
		wr(t1_a, 8'h80);
		wr(run_a, 8'h22);
		pl(4, 1);
		rd(run_a, 8'h00);
		wr(t1_a, 8'h00);
		wr(run_a, 8'hee);
		pl(4, 1);
		rd(run_a, 8'he0);
		chk_pin({uf, act, irq}, 5'h0f);
		pl(7, 1);
		rd(run_a, 8'h60);
		chk_pin({uf, act, irq}, 5'h07);
		wr(run_a, 8'hff);
		rd(run_a, 8'hf0);
		fin("timer1 and flags");
		give_verdict;
	end
endmodule // rf_frontend_timer_bank_bench
